// file: core/ucn_pkg.sv
package ucn_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFF_CONTROL3 = 8'h06;
  localparam logic [7:0] OFF_DATA     = 8'h07;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_MASK     = 8'h09;
  localparam logic [7:0] OFF_CONFIG   = 8'h0a;

  // serial_control_three fields
  localparam int unsigned C3_NINTH_RX = 7;
  localparam int unsigned C3_NINTH_TX = 6;
  localparam int unsigned C3_PIN_DIR  = 5;
  localparam int unsigned C3_TX_INV   = 4;

  // error bits, shared by status, mask and the enables of control three
  localparam int unsigned ERR_OVERRUN = 3;
  localparam int unsigned ERR_NOISE   = 2;
  localparam int unsigned ERR_FRAMING = 1;
  localparam int unsigned ERR_PARITY  = 0;

  // status fields
  localparam int unsigned ST_RX_FULL  = 7;
  localparam int unsigned ST_TX_EMPTY = 6;

  // config fields
  localparam int unsigned CFG_NINE   = 0;
  localparam int unsigned CFG_LOOP   = 1;
  localparam int unsigned CFG_RECEIVE_SOURCE_SELECT   = 2;
  localparam int unsigned CFG_PARITY = 3;

  // reset values
  localparam logic [6:0] RST_CONTROL3 = 7'h00;
  localparam logic [3:0] RST_CONFIG   = 4'h0;
  localparam logic [3:0] RST_MASK     = 4'h0;
  localparam logic [3:0] RST_FLAGS    = 4'h0;

  // bit timing
  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned BIT_NS   = 8680;
  localparam logic [9:0]  BIT_CYC  = 10'(BIT_NS / CLK_NS);
  localparam logic [9:0]  BIT_LAST = BIT_CYC - 10'h001;
  localparam logic [9:0]  BIT_HALF = BIT_CYC >> 1;

  // frame lengths including start and stop
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;

  typedef enum logic {RX_IDLE, RX_BUSY} ucn_rx_state_type;

endpackage : ucn_pkg

// file: core/ucn_top.sv
module ucn_top (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic       rx_pin,
  input  wire logic       tx_pin_in,
  output logic            tx_pin_out,
  output logic            tx_pin_oe
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  ucn_tx_if tx ();

  logic [6:0] c3_q;
  logic       ninth_rx_q;
  logic [3:0] cfg_q;
  logic [3:0] mask_q;
  logic [3:0] flags_q;
  logic       rx_full_q;
  logic [7:0] rx_data_q;
  logic [7:0] tx_buf_q;
  logic       tx_pend_q;
  logic [7:0] rdata_q;
  logic       irq_q;
  logic       tx_out_q;
  logic       tx_oe_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  ucn_pkg::ucn_rx_state_type rx_st_q;
  logic [9:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [2:0] smp_q;
  logic [8:0] rx_sh_q;
  logic       nz_q;

  logic       wr_c3;
  logic       wr_data;
  logic       wr_status;
  logic       wr_mask;
  logic       wr_cfg;
  logic       rd_data;
  logic       nine;
  logic       single_wire;
  logic       rx_src;
  logic       bit_end;
  logic       smp_pt;
  logic       eval;
  logic       maj;
  logic       disagree;
  logic [3:0] stop_idx;
  logic       data_bit;
  logic       rx_done;
  logic       accept;
  logic       pe_now;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] flags_d;
  logic [7:0] rdata_d;
  logic       tx_empty;

  // register decode
  assign wr_c3     = reg_write & hit(reg_addr, ucn_pkg::OFF_CONTROL3);
  assign wr_data   = reg_write & hit(reg_addr, ucn_pkg::OFF_DATA);
  assign wr_status = reg_write & hit(reg_addr, ucn_pkg::OFF_STATUS);
  assign wr_mask   = reg_write & hit(reg_addr, ucn_pkg::OFF_MASK);
  assign wr_cfg    = reg_write & hit(reg_addr, ucn_pkg::OFF_CONFIG);
  assign rd_data   = reg_read & hit(reg_addr, ucn_pkg::OFF_DATA);

  assign nine        = cfg_q[ucn_pkg::CFG_NINE];
  assign single_wire = cfg_q[ucn_pkg::CFG_LOOP] & cfg_q[ucn_pkg::CFG_RECEIVE_SOURCE_SELECT];
  assign tx_empty    = ~tx_pend_q & ~tx.busy;

  // transmit: ninth bit is sampled at the transfer, not at the data write
  assign tx.load = tx_pend_q & ~tx.busy;
  assign tx.word = {c3_q[ucn_pkg::C3_NINTH_TX], tx_buf_q};
  assign tx.nine = nine;

  ucn_tx_serializer u_tx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tx      (tx.ser)
  );

  // receive source: pin, internal loop, or the shared single-wire pin
  assign rx_src = single_wire ? sync2_q[1]
                : cfg_q[ucn_pkg::CFG_LOOP] ? tx.line : sync2_q[0];

  assign bit_end  = rx_cnt_q == ucn_pkg::BIT_LAST;
  assign smp_pt   = (rx_cnt_q == ucn_pkg::BIT_HALF - 10'h001)
                  | (rx_cnt_q == ucn_pkg::BIT_HALF)
                  | (rx_cnt_q == ucn_pkg::BIT_HALF + 10'h001);
  assign eval     = (rx_st_q == ucn_pkg::RX_BUSY)
                  & (rx_cnt_q == ucn_pkg::BIT_HALF + 10'h002);
  assign maj      = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2])
                  | (smp_q[0] & smp_q[2]);
  assign disagree = (smp_q != 3'h0) & (smp_q != 3'h7);
  assign stop_idx = nine ? 4'h9 + 4'h1 : 4'h9;
  assign data_bit = (rx_idx_q != 4'h0) & (rx_idx_q != stop_idx);
  assign rx_done  = eval & (rx_idx_q == stop_idx);
  assign accept   = rx_done & ~rx_full_q;
  // even parity over every data bit when enabled
  assign pe_now   = cfg_q[ucn_pkg::CFG_PARITY]
                  & (nine ? ^rx_sh_q : ^rx_sh_q[8:1]);

  // hardware sets win over a same-cycle write-one clear
  assign flag_set = {rx_done & rx_full_q, accept & (nz_q | disagree),
                     accept & ~maj, accept & pe_now};
  assign flag_clr = wr_status ? reg_wdata[3:0] : 4'h0;
  assign flags_d  = (flags_q & ~flag_clr) | flag_set;

  assign rdata_d =
      hit(reg_addr, ucn_pkg::OFF_CONTROL3) ? {ninth_rx_q, c3_q}
    : hit(reg_addr, ucn_pkg::OFF_DATA)     ? rx_data_q
    : hit(reg_addr, ucn_pkg::OFF_STATUS)   ? {rx_full_q, tx_empty,
                                              2'b00, flags_q}
    : hit(reg_addr, ucn_pkg::OFF_MASK)     ? {4'h0, mask_q}
    : hit(reg_addr, ucn_pkg::OFF_CONFIG)   ? {4'h0, cfg_q}
    : 8'h00;

  assign reg_rdata  = rdata_q;
  assign irq        = irq_q;
  assign tx_pin_out = tx_out_q;
  assign tx_pin_oe  = tx_oe_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      c3_q   <= ucn_pkg::RST_CONTROL3;
      cfg_q  <= ucn_pkg::RST_CONFIG;
      mask_q <= ucn_pkg::RST_MASK;
    end else begin
      if (wr_c3)
        c3_q <= reg_wdata[6:0];
      if (wr_cfg)
        cfg_q <= reg_wdata[3:0];
      if (wr_mask)
        mask_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_pend_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else if (wr_data) begin
      tx_pend_q <= 1'b1;
      tx_buf_q  <= reg_wdata;
    end else if (tx.load) begin
      tx_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_q    <= ucn_pkg::RST_FLAGS;
      rx_full_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      ninth_rx_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // a data read ends the clearing sequence; new data may then land
      if (accept)
        rx_full_q <= 1'b1;
      else if (rd_data)
        rx_full_q <= 1'b0;
      if (accept)
        rx_data_q <= nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
      if (accept & nine)
        ninth_rx_q <= rx_sh_q[8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      tx_out_q <= 1'b1;
      tx_oe_q  <= 1'b1;
      sync1_q  <= 2'b11;
      sync2_q  <= 2'b11;
    end else begin
      rdata_q  <= reg_read ? rdata_d : 8'h00;
      irq_q    <= |(flags_q & mask_q & c3_q[3:0]);
      tx_out_q <= tx.line ^ c3_q[ucn_pkg::C3_TX_INV];
      tx_oe_q  <= single_wire ? c3_q[ucn_pkg::C3_PIN_DIR] : 1'b1;
      sync1_q  <= {tx_pin_in, rx_pin};
      sync2_q  <= sync1_q;
    end
  end

  // three samples around mid-bit; disagreement marks noise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_st_q  <= ucn_pkg::RX_IDLE;
      rx_cnt_q <= 10'h000;
      rx_idx_q <= 4'h0;
      smp_q    <= 3'h0;
      rx_sh_q  <= 9'h000;
      nz_q     <= 1'b0;
    end else begin
      case (rx_st_q)
        ucn_pkg::RX_IDLE: begin
          rx_cnt_q <= 10'h000;
          rx_idx_q <= 4'h0;
          nz_q     <= 1'b0;
          if (!rx_src)
            rx_st_q <= ucn_pkg::RX_BUSY;
        end
        ucn_pkg::RX_BUSY: begin
          rx_cnt_q <= bit_end ? 10'h000 : rx_cnt_q + 10'h001;
          if (bit_end)
            rx_idx_q <= rx_idx_q + 4'h1;
          if (smp_pt)
            smp_q <= {smp_q[1:0], rx_src};
          if (eval)
            nz_q <= nz_q | disagree;
          if (eval & data_bit)
            rx_sh_q <= {maj, rx_sh_q[8:1]};
          // a high start sample was a glitch; stop ends the frame early
          if (eval & ((rx_idx_q == 4'h0 & maj) | rx_done))
            rx_st_q <= ucn_pkg::RX_IDLE;
        end
        default: rx_st_q <= ucn_pkg::RX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_ninth_rx_load: assert property (accept && nine |=>
    ninth_rx_q == $past(rx_sh_q[8])) else $error("ninth rx bit not loaded");

  a_ninth_rx_keep: assert property (rx_done && !nine |=>
    $stable(ninth_rx_q)) else $error("ninth rx bit moved in 8-bit mode");

  a_rx_full_clear: assert property (rd_data && !accept |=>
    !rx_full_q) else $error("data read left receive full");

  a_tx_word_pair: assert property (
    wr_data && tx_empty |=> tx.load &&
    tx.word == {$past(c3_q[ucn_pkg::C3_NINTH_TX]), $past(reg_wdata)})
    else $error("nine-bit word not transferred");

  a_ninth_tx_keep: assert property (wr_data |=>
    $stable(c3_q[ucn_pkg::C3_NINTH_TX])) else $error("ninth tx bit moved");

  a_pin_direction: assert property (single_wire |=>
    tx_pin_oe == $past(c3_q[ucn_pkg::C3_PIN_DIR]))
    else $error("single-wire direction wrong");

  a_tx_invert: assert property (1'b1 |=>
    tx_pin_out == ($past(tx.line) ^ $past(c3_q[ucn_pkg::C3_TX_INV])))
    else $error("transmit polarity wrong");

  a_irq_overrun: assert property (
    flags_q[ucn_pkg::ERR_OVERRUN] && mask_q[ucn_pkg::ERR_OVERRUN]
    && c3_q[ucn_pkg::ERR_OVERRUN] |=> irq) else $error("overrun irq lost");

  a_irq_noise: assert property (
    flags_q[ucn_pkg::ERR_NOISE] && mask_q[ucn_pkg::ERR_NOISE]
    && c3_q[ucn_pkg::ERR_NOISE] |=> irq) else $error("noise irq lost");

  a_irq_quiet: assert property (
    (flags_q & mask_q & c3_q[3:0]) == 4'h0 |=> !irq)
    else $error("irq without enabled flag");

  a_data_read: assert property (rd_data |=>
    reg_rdata == $past(rx_data_q)) else $error("data read not receive buffer");

endmodule : ucn_top

// file: core/ucn_tx_if.sv
interface ucn_tx_if;
  logic       load;
  logic [8:0] word;
  logic       nine;
  logic       busy;
  logic       line;

  modport ctrl (output load, output word, output nine,
                input busy, input line);
  modport ser  (input load, input word, input nine,
                output busy, output line);
endinterface : ucn_tx_if

// file: core/ucn_tx_serializer.sv
module ucn_tx_serializer (
  input  wire logic sys_clk,
  input  wire logic reset,
  ucn_tx_if.ser     tx
);

  logic [10:0] frame_q;
  logic [3:0]  bits_q;
  logic [9:0]  cnt_q;
  logic        busy_q;
  logic        line_q;
  logic        take;
  logic        bit_end;
  logic [10:0] frame_new;

  assign take      = tx.load & ~busy_q;
  assign bit_end   = busy_q & (cnt_q == ucn_pkg::BIT_LAST);
  // 8-bit frames drop the ninth bit entirely
  assign frame_new = tx.nine ? {1'b1, tx.word, 1'b0}
                             : {2'b11, tx.word[7:0], 1'b0};
  assign tx.busy   = busy_q;
  assign tx.line   = line_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_q <= 11'h7ff;
      bits_q  <= 4'h0;
      cnt_q   <= 10'h000;
      busy_q  <= 1'b0;
      line_q  <= 1'b1;
    end else if (take) begin
      frame_q <= frame_new;
      bits_q  <= tx.nine ? ucn_pkg::FRAME9 : ucn_pkg::FRAME8;
      cnt_q   <= 10'h000;
      busy_q  <= 1'b1;
      line_q  <= 1'b0;
    end else if (bit_end) begin
      frame_q <= {1'b1, frame_q[10:1]};
      bits_q  <= bits_q - 4'h1;
      cnt_q   <= 10'h000;
      busy_q  <= (bits_q != 4'h1);
      line_q  <= (bits_q == 4'h1) | frame_q[1];
    end else if (busy_q) begin
      cnt_q   <= cnt_q + 10'h001;
    end
  end

  sequence s_accept;
    tx.load && !busy_q;
  endsequence

  sequence s_start_bit;
    busy_q && !line_q;
  endsequence

  a_tx_start_bit: assert property (@(posedge sys_clk) disable iff (reset)
    s_accept |=> s_start_bit) else $error("start bit missing");

  a_tx_idle_high: assert property (@(posedge sys_clk) disable iff (reset)
    !busy_q |-> line_q) else $error("idle line not high");

endmodule : ucn_tx_serializer

// file: tb/test_uart_control3_ninth_bit_irq.sv
module test_uart_control3_ninth_bit_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset, reg_write, reg_read, irq, rx_raw, flip;
  logic        rd_d = 1'b0;
  logic        last = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, keep;
  logic        rx_pin, tx_pin_in, tx_pin_out, tx_pin_oe;
  logic        inv, nine, word_ok;
  logic [9:0]  word;
  logic [31:0] rs = 32'hc4ea;
  logic [9:0]  exp_rd[$];
  logic [9:0]  exp_tx[$];
  int          n_fail = 0;
  int          cmp_count = 0;

  // released pin shows the inverse of its last driven level
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : ~last;
  always @(posedge sys_clk) if (tx_pin_oe) last <= tx_pin_out;
  // a one-cycle spike on the receive pin hits one of the three samples
  assign rx_pin = rx_raw ^ flip;

  ucn_top ucn_top_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .rx_pin(rx_pin), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe));
  ucn_remote ucn_remote_i (.sys_clk(sys_clk), .tx_line(tx_pin_out),
    .inv(inv), .nine(nine), .rx_line(rx_raw), .word(word),
    .word_ok(word_ok));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    d = rs[7:0];
  endtask : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic chk(input logic [9:0] e, input logic [9:0] a);
    cmp_count++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    exp_rd.push_back({2'b00, e});
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask : rd
  task automatic wait_tx();
    int k;
    for (k = 0; k < 12000; k++) begin
      @(posedge sys_clk);
      if (word_ok === 1'b1) break;
    end
    if (k == 12000) n_fail++;
    @(posedge sys_clk);
  endtask : wait_tx
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1) chk(exp_rd.pop_front(), {2'b00, reg_rdata});
    if (word_ok === 1'b1) chk(exp_tx.pop_front(), word);
    rd_d <= reg_read;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    {reg_write, reg_read, inv, nine, flip} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    tick(20);
    reset <= 1'b0;
    rd(ucn_pkg::OFF_CONTROL3, 8'h00);
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'h00);
    wr(ucn_pkg::OFF_CONTROL3, 8'hff);
    rd(ucn_pkg::OFF_CONTROL3, 8'h7f);
    wr(ucn_pkg::OFF_CONTROL3, 8'h00);
    tick(900);
    $display("test registers done");
    nine <= 1'b1;
    wr(ucn_pkg::OFF_CONFIG, 8'h01);
    wr(ucn_pkg::OFF_CONTROL3, 8'h40);
    rnd();
    exp_tx.push_back({2'b11, d});
    wr(ucn_pkg::OFF_DATA, d);
    wait_tx();
    rnd();
    exp_tx.push_back({2'b11, d});
    wr(ucn_pkg::OFF_DATA, d);
    wait_tx();
    nine <= 1'b0;
    wr(ucn_pkg::OFF_CONFIG, 8'h00);
    // ninth bit low: a leaked ninth bit would spoil the stop bit
    wr(ucn_pkg::OFF_CONTROL3, 8'h10);
    tick(3);
    inv <= 1'b1;
    chk(10'(tx_pin_out), 10'h000);
    // let the remote drop the false start seen while inv lagged
    tick(440);
    rnd();
    exp_tx.push_back({2'b10, d});
    wr(ucn_pkg::OFF_DATA, d);
    wait_tx();
    wr(ucn_pkg::OFF_CONTROL3, 8'h00);
    tick(3);
    inv <= 1'b0;
    $display("test transmit done");
    wr(ucn_pkg::OFF_CONFIG, 8'h01);
    rnd();
    ucn_remote_i.send({2'b11, d, 1'b0}, 11);
    rd(ucn_pkg::OFF_CONTROL3, 8'h80);
    rd(ucn_pkg::OFF_DATA, d);
    $display("test receive done");
    wr(ucn_pkg::OFF_CONFIG, 8'h00);
    wr(ucn_pkg::OFF_MASK, 8'h0f);
    rnd();
    ucn_remote_i.send({2'b00, d, 1'b0}, 10);
    keep = d;
    rd(ucn_pkg::OFF_STATUS, 8'hc2);
    chk(10'(irq), 10'h000);
    wr(ucn_pkg::OFF_CONTROL3, 8'h02);
    tick(2);
    chk(10'(irq), 10'h001);
    wr(ucn_pkg::OFF_STATUS, 8'h02);
    tick(2);
    chk(10'(irq), 10'h000);
    rnd();
    ucn_remote_i.send({2'b01, d, 1'b0}, 10);
    rd(ucn_pkg::OFF_STATUS, 8'hc8);
    chk(10'(irq), 10'h000);
    wr(ucn_pkg::OFF_CONTROL3, 8'h08);
    tick(2);
    chk(10'(irq), 10'h001);
    wr(ucn_pkg::OFF_MASK, 8'h00);
    tick(2);
    chk(10'(irq), 10'h000);
    // overrun left the earlier byte in place
    rd(ucn_pkg::OFF_DATA, keep);
    wr(ucn_pkg::OFF_STATUS, 8'h0f);
    wr(ucn_pkg::OFF_MASK, 8'h0f);
    wr(ucn_pkg::OFF_CONFIG, 8'h08);
    rnd();
    // odd byte trips parity; a spike in mid bit two trips noise
    fork
      ucn_remote_i.send({2'b11, ~^d[6:0], d[6:0], 1'b0}, 10);
      begin
        tick(2171);
        flip <= 1'b1;
        tick(1);
        flip <= 1'b0;
      end
    join
    rd(ucn_pkg::OFF_STATUS, 8'hc5);
    rd(ucn_pkg::OFF_DATA, {~^d[6:0], d[6:0]});
    chk(10'(irq), 10'h000);
    wr(ucn_pkg::OFF_CONTROL3, 8'h04);
    tick(2);
    chk(10'(irq), 10'h001);
    wr(ucn_pkg::OFF_CONTROL3, 8'h01);
    tick(2);
    chk(10'(irq), 10'h001);
    wr(ucn_pkg::OFF_STATUS, 8'h01);
    tick(2);
    chk(10'(irq), 10'h000);
    $display("test interrupts done");
    wr(ucn_pkg::OFF_CONFIG, 8'h06);
    wr(ucn_pkg::OFF_CONTROL3, 8'h20);
    tick(2);
    chk(10'(tx_pin_oe), 10'h001);
    wr(ucn_pkg::OFF_CONTROL3, 8'h00);
    tick(2);
    chk(10'(tx_pin_oe), 10'h000);
    wr(ucn_pkg::OFF_CONFIG, 8'h02);
    tick(2);
    chk(10'(tx_pin_oe), 10'h001);
    $display("test single wire done");
    stop_test();
  end
endmodule : test_uart_control3_ninth_bit_irq

// file: tb/ucn_remote.sv
module ucn_remote (
  input  wire logic       sys_clk,
  input  wire logic       tx_line,
  input  wire logic       inv,
  input  wire logic       nine,
  output logic            rx_line,
  output logic      [9:0] word,
  output logic            word_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] w;
  int         i;
  initial begin
    rx_line = 1'b1;
    word = 10'h000;
    word_ok = 1'b0;
  end
  // lsb first from bit 0 of f; line idles at mark
  task automatic send(input logic [10:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      rx_line <= f[k];
      repeat (868) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
  endtask : send
  // glitches shorter than half a bit die at the recheck
  always begin
    @(posedge sys_clk);
    if ((tx_line ^ inv) === 1'b0) begin
      repeat (434) @(posedge sys_clk);
      if ((tx_line ^ inv) === 1'b0) begin
        for (i = 0; i < (nine ? 10 : 9); i++) begin
          repeat (868) @(posedge sys_clk);
          w[i] = tx_line ^ inv;
        end
        if (!nine) w = {w[8], 1'b0, w[7:0]};
        word <= w;
        word_ok <= 1'b1;
        @(posedge sys_clk);
        word_ok <= 1'b0;
      end
    end
  end
endmodule : ucn_remote
